// ---- hw/tpo_pkg.sv ----
// Package with register map, reset values and shared types of the pattern output unit.
package tpo_pkg;

  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned GROUP_W    = 4;
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned PIN_W      = 16;
  localparam int unsigned FIFO_DEPTH = 2;

  // Register indices; the AXI byte address is four times the index.
  localparam logic [15:0] IDX_MODE          = 16'hffa0;
  localparam logic [15:0] IDX_TRIG          = 16'hffa1;
  localparam logic [15:0] IDX_EN_HIGH       = 16'hffa2;
  localparam logic [15:0] IDX_EN_LOW        = 16'hffa3;
  localparam logic [15:0] IDX_VAL_HIGH      = 16'hffa4;
  localparam logic [15:0] IDX_VAL_LOW       = 16'hffa5;
  localparam logic [15:0] IDX_VAL_HIGH_ALT  = 16'hffa6;
  localparam logic [15:0] IDX_VAL_LOW_ALT   = 16'hffa7;
  localparam logic [15:0] IDX_LOW_DIR       = 16'hffd1;
  localparam logic [15:0] IDX_LOW_LATCH     = 16'hffd3;
  localparam logic [15:0] IDX_HIGH_DIR      = 16'hffd4;
  localparam logic [15:0] IDX_HIGH_LATCH    = 16'hffd6;
  localparam int unsigned IDX_LSB           = 2;

  localparam logic [7:0]  RST_MODE          = 8'hf0;
  localparam logic [7:0]  RST_TRIG          = 8'hff;
  localparam logic [15:0] RST_ZERO          = 16'h0000;
  localparam logic [3:0]  RESERVED_NIBBLE   = 4'hf;
  localparam logic [7:0]  RESERVED_BYTE     = 8'hff;
  localparam int unsigned TRIG_FIELD_W      = 2;

  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } tpo_rd_type;

  typedef enum logic {
    TPO_WS_IDLE = 1'b0,
    TPO_WS_RESP = 1'b1
  } tpo_wstate_type;

  // Timer channel chosen as trigger for group g.
  function automatic logic [1:0] tpo_grp_trig(input logic [7:0] sel, input int g);
    return sel[g*TRIG_FIELD_W +: TRIG_FIELD_W];
  endfunction : tpo_grp_trig

  function automatic logic tpo_mapped(input logic [15:0] idx);
    return (idx >= IDX_MODE && idx <= IDX_VAL_LOW_ALT) || idx == IDX_LOW_DIR ||
           idx == IDX_LOW_LATCH || idx == IDX_HIGH_DIR || idx == IDX_HIGH_LATCH;
  endfunction : tpo_mapped

endpackage : tpo_pkg

// ---- hw/tpo_pattern_output.sv ----
// Timing pattern output unit with AXI4-Lite register slave.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// - Four independent 4-bit groups update simultaneously.
// - Sixteen outputs, each bit enabled separately.
// - Each group selects one of four timer channels.
// - Non-overlap mode separates rising and falling changes.
// - Selected compare B matches raise DMA requests.
// - Pins map to groups in nibble order.
// - Enabled latch bits ignore software writes.
// - Groups 0/1 next value address follows triggers.
// - Groups 2/3 next value address follows triggers.
// - Register index uses address bits 17:2.
// - Trigger copies next value into port latch.
// - Disabled bits are never copied, outputs hold.
// - Reserved next value nibbles read ones, ignore writes.
// - Control registers take initial values on reset.
module tpo_pattern_output (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [31:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [31:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [tpo_pkg::NUM_CH-1:0] cmp_a,
  input  wire logic [tpo_pkg::NUM_CH-1:0] cmp_b,
  output logic [tpo_pkg::PIN_W-1:0]     pattern_pin,
  output logic [tpo_pkg::PIN_W-1:0]     pattern_pin_oe,
  output logic [tpo_pkg::NUM_CH-1:0]    dma_req
);
  import tpo_pkg::*;

  logic [7:0]        mode;
  logic [7:0]        next_mode;
  logic [7:0]        trig;
  logic [7:0]        next_trig;
  logic [15:0]       en;
  logic [15:0]       next_en;
  logic [15:0]       val;
  logic [15:0]       next_val;
  logic [15:0]       dir;
  logic [15:0]       next_dir;
  logic [15:0]       latch;
  logic [15:0]       next_latch;
  logic [3:0]        dma_q;
  logic [3:0]        next_dma_q;
  logic [1:0]        grp_sel [NUM_GROUPS];
  logic [3:0]        fire_a;
  logic [3:0]        fire_b;
  logic [15:0]       xfer_set;
  logic [15:0]       xfer_clr;
  logic [3:0]        dma_hit;
  logic              shared_low;
  logic              shared_high;

  tpo_wstate_type    wstate;
  tpo_wstate_type    next_wstate;
  logic              aw_held;
  logic              next_aw_held;
  logic              w_held;
  logic              next_w_held;
  logic [15:0]       aw_idx;
  logic [15:0]       next_aw_idx;
  logic [7:0]        w_byte;
  logic [7:0]        next_w_byte;
  logic              w_lane;
  logic              next_w_lane;
  logic [1:0]        bresp_q;
  logic [1:0]        next_bresp;
  logic              wr_fire;

  tpo_rd_type        fifo_mem [FIFO_DEPTH];
  tpo_rd_type        next_fifo_mem [FIFO_DEPTH];
  logic              rd_ptr;
  logic              next_rd_ptr;
  logic              wr_ptr;
  logic              next_wr_ptr;
  logic [1:0]        fcnt;
  logic [1:0]        next_fcnt;
  logic              ar_fire;
  logic              r_fire;
  tpo_rd_type        rd_word;

  // Trigger selection and per-group transfer masks.
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gen_group
      assign grp_sel[g] = tpo_grp_trig(trig, g);
      assign fire_a[g]  = cmp_a[grp_sel[g]];
      assign fire_b[g]  = cmp_b[grp_sel[g]];
      // In non-overlap mode rising bits wait for the A match, falling bits for B.
      assign xfer_set[g*GROUP_W +: GROUP_W] = en[g*GROUP_W +: GROUP_W]
        & val[g*GROUP_W +: GROUP_W] & {GROUP_W{mode[g] ? fire_a[g] : fire_b[g]}};
      assign xfer_clr[g*GROUP_W +: GROUP_W] = en[g*GROUP_W +: GROUP_W]
        & ~val[g*GROUP_W +: GROUP_W] & {GROUP_W{fire_b[g]}};
    end
    for (g = 0; g < NUM_CH; g++) begin : gen_dma
      assign dma_hit[g] = cmp_b[g] & ((grp_sel[0] == 2'(g)) | (grp_sel[1] == 2'(g)) |
                                      (grp_sel[2] == 2'(g)) | (grp_sel[3] == 2'(g)));
    end
  endgenerate

  assign shared_low  = grp_sel[0] == grp_sel[1];
  assign shared_high = grp_sel[2] == grp_sel[3];

  // Register file and port latch.
  assign wr_fire = (wstate == TPO_WS_IDLE) && aw_held && w_held;

  always_comb begin
    next_mode  = mode;
    next_trig  = trig;
    next_en    = en;
    next_val   = val;
    next_dir   = dir;
    next_latch = latch;
    if (wr_fire && w_lane) begin
      unique case (aw_idx)
        IDX_MODE:       next_mode[3:0] = w_byte[3:0];
        IDX_TRIG:       next_trig = w_byte;
        IDX_EN_HIGH:    next_en[15:8] = w_byte;
        IDX_EN_LOW:     next_en[7:0] = w_byte;
        IDX_VAL_HIGH:   next_val[15:8] = {w_byte[7:4],
                                          shared_high ? w_byte[3:0] : val[11:8]};
        IDX_VAL_HIGH_ALT: next_val[11:8] = shared_high ? val[11:8] : w_byte[3:0];
        IDX_VAL_LOW:    next_val[7:0] = {w_byte[7:4],
                                         shared_low ? w_byte[3:0] : val[3:0]};
        IDX_VAL_LOW_ALT: next_val[3:0] = shared_low ? val[3:0] : w_byte[3:0];
        IDX_LOW_DIR:    next_dir[7:0] = w_byte;
        IDX_HIGH_DIR:   next_dir[15:8] = w_byte;
        IDX_LOW_LATCH:  next_latch[7:0] = (w_byte & ~en[7:0]) | (latch[7:0] & en[7:0]);
        IDX_HIGH_LATCH: next_latch[15:8] = (w_byte & ~en[15:8]) | (latch[15:8] & en[15:8]);
        default:        next_mode = mode;
      endcase
    end
    // Software only reaches disabled bits and triggers only enabled ones, so no clash.
    next_latch = (next_latch & ~xfer_clr) | xfer_set;
    next_dma_q = dma_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode  <= RST_MODE;
      trig  <= RST_TRIG;
      en    <= RST_ZERO;
      val   <= RST_ZERO;
      dir   <= RST_ZERO;
      latch <= RST_ZERO;
      dma_q <= 4'h0;
    end else begin
      mode  <= next_mode;
      trig  <= next_trig;
      en    <= next_en;
      val   <= next_val;
      dir   <= next_dir;
      latch <= next_latch;
      dma_q <= next_dma_q;
    end
  end

  assign pattern_pin    = latch;
  assign pattern_pin_oe = dir;
  assign dma_req        = dma_q;

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = (wstate == TPO_WS_IDLE) && !aw_held;
  assign s_axi_wready  = (wstate == TPO_WS_IDLE) && !w_held;
  assign s_axi_bvalid  = wstate == TPO_WS_RESP;
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    next_wstate  = wstate;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bresp   = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr[IDX_LSB +: 16];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    unique case (wstate)
      TPO_WS_IDLE: begin
        if (wr_fire) begin
          next_wstate  = TPO_WS_RESP;
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bresp   = tpo_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      TPO_WS_RESP: begin
        if (s_axi_bready) begin
          next_wstate = TPO_WS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate  <= TPO_WS_IDLE;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 16'h0000;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      wstate  <= next_wstate;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_idx  <= next_aw_idx;
      w_byte  <= next_w_byte;
      w_lane  <= next_w_lane;
      bresp_q <= next_bresp;
    end
  end

  // Read path: the answer is captured at acceptance and queued, so a stalled
  // receiver only blocks new addresses and never loses a word.
  function automatic tpo_rd_type read_reg(input logic [15:0] idx);
    tpo_rd_type r;
    r.data = 32'h0000_0000;
    r.resp = RESP_OKAY;
    unique case (idx)
      IDX_MODE:         r.data[7:0] = mode;
      IDX_TRIG:         r.data[7:0] = trig;
      IDX_EN_HIGH:      r.data[7:0] = en[15:8];
      IDX_EN_LOW:       r.data[7:0] = en[7:0];
      IDX_VAL_HIGH:     r.data[7:0] = {val[15:12], shared_high ? val[11:8] : RESERVED_NIBBLE};
      IDX_VAL_HIGH_ALT: r.data[7:0] = shared_high ? RESERVED_BYTE
                                                  : {RESERVED_NIBBLE, val[11:8]};
      IDX_VAL_LOW:      r.data[7:0] = {val[7:4], shared_low ? val[3:0] : RESERVED_NIBBLE};
      IDX_VAL_LOW_ALT:  r.data[7:0] = shared_low ? RESERVED_BYTE
                                                 : {RESERVED_NIBBLE, val[3:0]};
      IDX_LOW_LATCH:    r.data[7:0] = latch[7:0];
      IDX_HIGH_LATCH:   r.data[7:0] = latch[15:8];
      IDX_LOW_DIR, IDX_HIGH_DIR: r.data = 32'h0000_0000;
      default:          r.resp = RESP_SLVERR;
    endcase
    return r;
  endfunction : read_reg

  assign s_axi_arready = fcnt != 2'd2;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = fcnt != 2'd0;
  assign r_fire        = s_axi_rvalid && s_axi_rready;
  assign s_axi_rdata   = fifo_mem[rd_ptr].data;
  assign s_axi_rresp   = fifo_mem[rd_ptr].resp;

  // The function reads the registers directly, so only always_comb sees them change.
  always_comb begin
    rd_word = read_reg(s_axi_araddr[IDX_LSB +: 16]);
  end

  always_comb begin
    next_fifo_mem = fifo_mem;
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_fcnt     = fcnt;
    if (ar_fire) begin
      next_fifo_mem[wr_ptr] = rd_word;
      next_wr_ptr           = ~wr_ptr;
    end
    if (r_fire) begin
      next_rd_ptr = ~rd_ptr;
    end
    next_fcnt = 2'(fcnt + {1'b0, ar_fire} - {1'b0, r_fire});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      fcnt        <= 2'd0;
    end else begin
      fifo_mem <= next_fifo_mem;
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      fcnt     <= next_fcnt;
    end
  end

  logic sw_low_latch;
  assign sw_low_latch = wr_fire && w_lane && aw_idx == IDX_LOW_LATCH;

  a_group_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    fire_b[0] && !mode[0] |=> (latch[3:0] & $past(en[3:0])) == ($past(val[3:0]) & $past(en[3:0])))
    else $error("group 0 did not copy next value on trigger");
  a_disabled_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !en[0] && !sw_low_latch |=> latch[0] == $past(latch[0]))
    else $error("disabled bit changed without software write");
  a_latch_sw_block: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_low_latch && fire_a[1:0] == 2'b00 && fire_b[1:0] == 2'b00
    |=> (latch[7:0] & $past(en[7:0])) == ($past(latch[7:0]) & $past(en[7:0])))
    else $error("software write reached an enabled latch bit");
  a_reset_values: assert property (@(posedge aclk)
    !aresetn |=> mode == RST_MODE && trig == RST_TRIG && en == RST_ZERO && val == RST_ZERO)
    else $error("control registers not at reset values");
  a_dma_request: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_b[grp_sel[2]] |=> dma_req[$past(grp_sel[2])])
    else $error("selected compare match raised no DMA request");
  a_grp1_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(latch[7:4]) && !$past(sw_low_latch) |-> $past(fire_a[1] | fire_b[1]))
    else $error("group 1 changed without its trigger");
  a_nov_margin: assert property (@(posedge aclk) disable iff (!aresetn)
    mode[0] && fire_a[0] && !fire_b[0] && !sw_low_latch |=> ($past(latch[3:0]) & ~latch[3:0]) == 4'h0)
    else $error("non-overlap A match cleared an output");
  a_reserved_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && shared_low && s_axi_araddr[IDX_LSB +: 16] == IDX_VAL_LOW_ALT
    |=> fifo_mem[$past(wr_ptr)].data[7:0] == RESERVED_BYTE)
    else $error("reserved next value address did not read ones");
  a_split_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && w_lane && aw_idx == IDX_VAL_HIGH && !shared_high |=> val[11:8] == $past(val[11:8]))
    else $error("split high next value took a write at the shared address");

endmodule : tpo_pattern_output

// ---- verif/tpo_timer_model.sv ----
// Model of the timer unit that raises the compare-match pulses.
`timescale 1ns/1ps
module tpo_timer_model (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [tpo_pkg::NUM_CH-1:0] fire_a,
  input  wire logic [tpo_pkg::NUM_CH-1:0] fire_b,
  output logic      [tpo_pkg::NUM_CH-1:0] cmp_a,
  output logic      [tpo_pkg::NUM_CH-1:0] cmp_b
);
  import tpo_pkg::*;

  // Matches come out of a flip-flop, one cycle after each request and for as many cycles as it is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a <= '0;
      cmp_b <= '0;
    end else begin
      cmp_a <= fire_a;
      cmp_b <= fire_b;
    end
  end
endmodule : tpo_timer_model

// ---- verif/test_tpo_pattern_output.sv ----
// Self-checking testbench of the pattern output unit.
`timescale 1ns/1ps
module test_tpo_pattern_output;
  import tpo_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_data, seed;
  logic [3:0]  wstrb, fa, fb, ca, cb, dma, sel;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  logic [15:0] pins, oe, exp_pin, nv, en;
  int          err_total, checks_done, cyc;

  tpo_pattern_output i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_a(ca), .cmp_b(cb), .pattern_pin(pins),
    .pattern_pin_oe(oe), .dma_req(dma));
  tpo_timer_model i_tmr (.aclk(aclk), .aresetn(aresetn), .fire_a(fa), .fire_b(fb),
    .cmp_a(ca), .cmp_b(cb));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [15:0] upd(input logic [15:0] o, v, e);
    return (o & ~e) | (v & e);
  endfunction : upd

  task automatic end_of_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge; ready only moves on rising edges.
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic a, w, b;
    int   n;
    @(posedge aclk);
    awaddr  <= {14'h0, idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b && n < 50) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      wr_resp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
    end
    chk({31'h0, b}, 32'h1, "write answer");
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [13:0] hi);
    logic a, r;
    int   n;
    @(posedge aclk);
    araddr  <= {hi, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r = 1'b0;
    n = 0;
    while (!r && n < 50) begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid && rready;
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
      n++;
    end
    chk({31'h0, r}, 32'h1, "read answer");
  endtask : rd

  task automatic fire(input logic [3:0] a, input logic [3:0] b);
    @(posedge aclk);
    fa <= a;
    fb <= b;
    @(posedge aclk);
    fa <= 4'h0;
    fb <= 4'h0;
    @(posedge aclk);
    @(negedge aclk);
    chk({28'h0, dma}, {28'h0, b & sel}, "dma request");
    chk({16'h0, pins}, {16'h0, exp_pin}, "pins after trigger");
  endtask : fire

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb, fa, fb} = '0;
    {err_total, checks_done, cyc} = '0;
    seed = 32'd77;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (seed[i]) if (i < 6) begin
      rd(IDX_MODE + 16'(i), 14'h0);
      chk(rd_data, (i == 0) ? 32'hf0 : (i == 1) ? 32'hff : 32'h0, "reset value");
    end
    rd(IDX_MODE, 14'h2a5f);
    chk(rd_data, 32'hf0, "upper address bits");
    rd(16'hffb0, 14'h0);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(16'hffb0, 8'h12);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    wr(IDX_VAL_LOW_ALT, 8'h00);
    rd(IDX_VAL_LOW_ALT, 14'h0);
    chk(rd_data, 32'hff, "shared alt address");
    wr(IDX_LOW_DIR, 8'hff);
    wr(IDX_HIGH_DIR, 8'hff);
    chk({30'h0, wr_resp}, {30'h0, RESP_OKAY}, "mapped write");
    rd(IDX_LOW_DIR, 14'h0);
    chk(rd_data, 32'h0, "direction reads zero");
    chk({30'h0, rd_resp}, {30'h0, RESP_OKAY}, "mapped read");
    chk({16'h0, oe}, 32'hffff, "drive enables");
    exp_pin = 16'h0;
    sel = 4'h8;
    // Channel 3 drives all groups; random enables exercise per-bit gating.
    repeat (4) begin
      seed = xs(seed);
      en = seed[15:0];
      nv = seed[31:16];
      wr(IDX_EN_HIGH, en[15:8]);
      wr(IDX_EN_LOW, en[7:0]);
      wr(IDX_VAL_HIGH, nv[15:8]);
      wr(IDX_VAL_LOW, nv[7:0]);
      fire(4'h0, 4'h7);
      chk({16'h0, pins}, {16'h0, exp_pin}, "unselected channels");
      exp_pin = upd(exp_pin, nv, en);
      fire(4'h0, 4'h8);
      wr(IDX_LOW_LATCH, ~nv[7:0]);
      exp_pin = upd(exp_pin, {8'h00, ~nv[7:0]}, {8'h00, ~en[7:0]});
      rd(IDX_LOW_LATCH, 14'h0);
      chk(rd_data, {24'h0, exp_pin[7:0]}, "latch write gating");
    end
    wr(IDX_TRIG, 8'he4);
    wr(IDX_EN_HIGH, 8'hff);
    wr(IDX_EN_LOW, 8'hff);
    sel = 4'hf;
    rd(IDX_VAL_LOW, 14'h0);
    chk(rd_data, {24'h0, nv[7:4], 4'hf}, "split upper nibble");
    rd(IDX_VAL_HIGH_ALT, 14'h0);
    chk(rd_data, {24'h0, 4'hf, nv[11:8]}, "split alt nibble");
    for (int g = 0; g < 4; g++) begin
      seed = xs(seed);
      wr(IDX_VAL_LOW_ALT, seed[7:0]);
      wr(IDX_VAL_LOW, seed[7:0]);
      wr(IDX_VAL_HIGH_ALT, seed[15:8]);
      wr(IDX_VAL_HIGH, seed[15:8]);
      nv = {seed[15:12], seed[11:8], seed[7:4], seed[3:0]};
      rd(IDX_VAL_LOW_ALT, 14'h0);
      chk(rd_data, {24'h0, 4'hf, nv[3:0]}, "reserved nibble");
      exp_pin[g*4 +: 4] = nv[g*4 +: 4];
      fire(4'h0, 4'(1 << g));
    end
    exp_pin = nv;
    fire(4'h0, 4'hf);
    wr(IDX_MODE, 8'h01);
    rd(IDX_MODE, 14'h0);
    chk(rd_data, 32'hf1, "mode upper bits");
    // Group 0 inverts: the rising half must land before the falling half.
    wr(IDX_VAL_LOW_ALT, {4'h0, ~exp_pin[3:0]});
    nv[3:0] = ~exp_pin[3:0];
    exp_pin[3:0] = 4'hf;
    fire(4'h1, 4'h0);
    exp_pin[3:0] = nv[3:0];
    fire(4'h0, 4'h1);
    // A reset in mid-run must restore mode, trigger select and low enables and release the pins.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({oe, pins}, 32'h0, "pins after reset");
    rd(IDX_MODE, 14'h0);
    chk(rd_data, 32'hf0, "mode after reset");
    rd(IDX_TRIG, 14'h0);
    chk(rd_data, 32'hff, "trigger select after reset");
    rd(IDX_EN_LOW, 14'h0);
    chk(rd_data, 32'h0, "enable after reset");
    end_of_test();
  end
endmodule : test_tpo_pattern_output
